// file: src/ascm_defs.svh
// offsets, field positions, reset values and divide counts of the block
`ifndef ASCM_DEFS_SVH
`define ASCM_DEFS_SVH

// register byte offsets on the bus
`define ASCM_OFF_CTRL_A0 8'h00
`define ASCM_OFF_CTRL_A1 8'h04
`define ASCM_OFF_CTRL_B0 8'h08
`define ASCM_OFF_CTRL_B1 8'h0C
`define ASCM_OFF_CHANNEL0_STATUS_REG 8'h10
`define ASCM_OFF_CHANNEL1_STATUS_REG 8'h14

// control a fields
`define ASCM_A_RTS 4
`define ASCM_A_CLOCK_PIN1_DISABLE 4
`define ASCM_A_PAR_EN 1

// status fields
`define ASCM_S_RX_HOLDING_FULL_FLAG 7
`define ASCM_S_OVERRUN_FLAG 6
`define ASCM_S_PE 5
`define ASCM_S_FE 4
`define ASCM_S_RIE 3
`define ASCM_S_DCD 2
`define ASCM_S_CH1_FLOW_INPUT_SELECT 2
`define ASCM_S_TX_HOLDING_EMPTY_FLAG 1
`define ASCM_S_TIE 0

// control b field holding the flow/prescale bit
`define ASCM_B_PS 5

// reset values and software-writable status bits
`define ASCM_RST_CTRL_A0 8'h10
`define ASCM_RST_CTRL_A1 8'h00
`define ASCM_RST_CTRL_B 8'h07
`define ASCM_RST_STAT 8'h00
`define ASCM_WMASK_CHANNEL0_STATUS_REG 8'h09
`define ASCM_WMASK_CHANNEL1_STATUS_REG 8'h0D

// divide counts
`define ASCM_PRESCALE_LO 10
`define ASCM_PRESCALE_HI 30
`define ASCM_SAMPLE_DIV_LO 16
`define ASCM_SAMPLE_DIV_HI 64
`define ASCM_SS_EXTERNAL 3'h7

`endif

// file: src/ascm_pkg.sv
// types shared by the serial clocking and modem block
package ascm_pkg;

  typedef struct packed {
    logic mpbt;
    logic mp;
    logic flow_or_prescale_bit;
    logic parity_odd_select;
    logic sample_divide_select;
    logic [2:0] speed_source;
  } ascm_ctrl_b_t;

  typedef struct packed {
    logic tx_holding_empty_flag;
    logic rx_holding_full_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_flag;
  } ascm_flags_t;

  typedef struct packed {
    logic clk_pin1;
    logic clk_pin0;
    logic rx_pin;
    logic carrier_n;
    logic clear_n;
  } ascm_pins_t;

  typedef enum logic [1:0] {
    ASCM_HTRANS_IDLE = 2'b00,
    ASCM_HTRANS_BUSY = 2'b01,
    ASCM_HTRANS_NONSEQ = 2'b10,
    ASCM_HTRANS_SEQ = 2'b11
  } ascm_htrans_t;

endpackage

// file: src/ascm_sync3.sv
// three-stage pin synchroniser, output moves once stages two and three agree
`timescale 1ns/100ps
module ascm_sync3
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_r
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
      begin
        s1_r[i] <= INIT[i];
        s2_r[i] <= INIT[i];
        s3_r[i] <= INIT[i];
        sync_r[i] <= INIT[i];
      end
      else
      begin
        s1_r[i] <= async_in[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        // agreement filter rejects a single-cycle glitch
        if (s2_r[i] == s3_r[i])
          sync_r[i] <= s3_r[i];
      end
    end
  end

endmodule

// file: src/ascm_baud_gen.sv
// one channel baud generator: prescale, speed divide, sample divide
`timescale 1ns/100ps
`include "ascm_defs.svh"
module ascm_baud_gen
#(
  parameter int PRE_W = 5
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input ascm_pkg::ascm_ctrl_b_t ctrl,
  input wire logic ext_clk_level,
  output logic sample_tick_r,
  output logic bit_tick_r,
  output logic data_clk_r
);
  import ascm_pkg::*;

  logic [PRE_W-1:0] pre_cnt_r;
  logic [PRE_W-1:0] pre_max;
  logic [PRE_W-1:0] pre_half;
  logic [5:0] speed_cnt_r;
  logic [5:0] speed_mask;
  logic [5:0] samp_cnt_r;
  logic [5:0] samp_max;
  logic [6:0] speed_pow;
  logic [2:0] speed_bit;
  logic ext_d_r;
  logic internal;
  logic pre_tick;
  logic samp_clk_tick;

  ////////////////////////////////////////////////////////////////////////////
  assign internal = ctrl.speed_source != `ASCM_SS_EXTERNAL;
  assign pre_max = ctrl.flow_or_prescale_bit ?
    PRE_W'(`ASCM_PRESCALE_HI - 1) : PRE_W'(`ASCM_PRESCALE_LO - 1);
  assign pre_half = ctrl.flow_or_prescale_bit ?
    PRE_W'(`ASCM_PRESCALE_HI / 2) : PRE_W'(`ASCM_PRESCALE_LO / 2);
  // >= also recovers when the prescale shrinks mid-count
  assign pre_tick = pre_cnt_r >= pre_max;
  assign speed_pow = 7'h01 << ctrl.speed_source;
  assign speed_mask = 6'(speed_pow - 7'h01);
  assign speed_bit = 3'(ctrl.speed_source - 3'h1);
  assign samp_max = ctrl.sample_divide_select ?
    6'(`ASCM_SAMPLE_DIV_HI - 1) : 6'(`ASCM_SAMPLE_DIV_LO - 1);
  // external edges come already synchronised from the top
  assign samp_clk_tick = internal ?
    (pre_tick && speed_cnt_r >= speed_mask) :
    (ext_clk_level && !ext_d_r);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !internal || pre_tick)
      pre_cnt_r <= '0;
    else
      pre_cnt_r <= PRE_W'(pre_cnt_r + 1'b1);
  end

  // >= recovers cleanly when the speed field shrinks mid-count
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !internal)
      speed_cnt_r <= 6'h00;
    else if (pre_tick)
      speed_cnt_r <= (speed_cnt_r >= speed_mask) ? 6'h00 :
        6'(speed_cnt_r + 6'h01);
  end

  always_ff @(posedge ref_clk)
  begin
    // synchronised clock pins reset high; matching it avoids a false edge
    if (!rst_n)
      ext_d_r <= 1'b1;
    else
      ext_d_r <= ext_clk_level;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      samp_cnt_r <= 6'h00;
    else if (samp_clk_tick)
      samp_cnt_r <= (samp_cnt_r >= samp_max) ? 6'h00 :
        6'(samp_cnt_r + 6'h01);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sample_tick_r <= 1'b0;
      bit_tick_r <= 1'b0;
      data_clk_r <= 1'b0;
    end
    else
    begin
      sample_tick_r <= samp_clk_tick;
      bit_tick_r <= samp_clk_tick && samp_cnt_r >= samp_max;
      if (!internal)
        data_clk_r <= 1'b0;
      else if (ctrl.speed_source == 3'h0)
        data_clk_r <= pre_cnt_r < pre_half;
      else
        data_clk_r <= speed_cnt_r[speed_bit];
    end
  end

endmodule

// file: src/ascm_top.sv
// two-channel serial clocking, parity select and modem control, ahb-lite
`timescale 1ns/100ps
`include "ascm_defs.svh"
//
// Function
// - parity odd select: 0 even, 1 odd; no effect on enable; resets 0.
// - sample divide select: 0 divides sampling clock by 16, 1 by 64.
// - speed field divides prescaled clock by 1..64; 111 picks external clock.
// - speed field resets to all ones, external clock by default.
// - clock pins inputs after reset; outputs when speed field not all ones.
// - dma channel 0 memory-io mode makes clock pin 0 the dma request.
// - clock pin 1 disable set makes pin 1 carry dma transfer end.
// - internal bit rate: clock / prescale / sampling divisor / speed divisor.
// - external clock feeds the 16 or 64 sampling divider directly.
// - clear-to-send high forces tx holding empty flag to 0.
// - clear-to-send only masks the flag; transmission keeps running.
// - carrier-detect high forces rx full and error flags to 0.
// - after carrier falls, flags stay held until next status read.
// - request-to-send is a plain output bit without side effects.
// - channel 1 clear-to-send on shared rx pin when select bit is 1.
// - reset stops operation, inits control bits, keeps holding registers.
// - channel 0 flags are offered to the dma controller as requests.
// - flow/prescale bit selects prescale 10 or 30; resets to 0.
// - tx holding empty flag reads 1 when holding register is empty.
module ascm_top
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic async_clock_pin0_i,
  output logic async_clock_pin0_o,
  output logic async_clock_pin0_oe,
  input wire logic async_clock_pin1_i,
  output logic async_clock_pin1_o,
  output logic async_clock_pin1_oe,
  input wire logic clear_to_send0_n,
  input wire logic carrier_detect0_n,
  output logic request_to_send0_n,
  input wire logic sync_serial_rx_pin,
  input wire logic dma0_mem_io,
  input wire logic dma_transfer_end_0_n,
  output logic dma_request_0_n,
  input ascm_pkg::ascm_flags_t raw_flags_ch0,
  input ascm_pkg::ascm_flags_t raw_flags_ch1,
  output ascm_pkg::ascm_flags_t flags_ch0,
  output ascm_pkg::ascm_flags_t flags_ch1,
  output logic [1:0] sample_tick,
  output logic [1:0] bit_tick,
  output logic [1:0] parity_odd,
  output logic [1:0] parity_enable
);
  import ascm_pkg::*;

  logic [7:0] ctrl_a_r [2];
  ascm_ctrl_b_t ctrl_b_r [2];
  logic [7:0] stat_en_r [2];
  logic [1:0] data_clk;
  logic [1:0] ext_clk;
  logic [1:0] cts_act;
  ascm_pins_t pins_in;
  ascm_pins_t pins_sy;
  ascm_flags_t gated [2];
  logic dcd_bit_r;
  logic hold_r;
  logic rx_hold;
  logic clock_pin1_disable;
  logic addr_ok;
  logic rd_channel0_status_reg;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [7:0] rd_val;
  logic [7:0] wr_byte;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; carrier and clear start low, clock pins high, so that reset
  // does not latch the carrier bit
  assign pins_in = '{clk_pin1: async_clock_pin1_i,
    clk_pin0: async_clock_pin0_i, rx_pin: sync_serial_rx_pin,
    carrier_n: carrier_detect0_n, clear_n: clear_to_send0_n};

  ascm_sync3 #(.W(5), .INIT(5'h18)) u_sync
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(pins_in),
    .sync_r(pins_sy)
  );

  assign clock_pin1_disable = ctrl_a_r[1][`ASCM_A_CLOCK_PIN1_DISABLE];
  assign ext_clk[0] = pins_sy.clk_pin0;
  assign ext_clk[1] = pins_sy.clk_pin1 && !clock_pin1_disable;

  ////////////////////////////////////////////////////////////////////////////
  // baud generators, one per channel
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    ascm_baud_gen #(.PRE_W(5)) u_baud
    (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ctrl(ctrl_b_r[c]),
      .ext_clk_level(ext_clk[c]),
      .sample_tick_r(sample_tick[c]),
      .bit_tick_r(bit_tick[c]),
      .data_clk_r(data_clk[c])
    );

    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
      begin
        parity_odd[c] <= 1'b0;
        parity_enable[c] <= 1'b0;
      end
      else
      begin
        parity_odd[c] <= ctrl_b_r[c].parity_odd_select;
        parity_enable[c] <= ctrl_a_r[c][`ASCM_A_PAR_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag gating by the modem lines
  assign cts_act[0] = pins_sy.clear_n;
  assign cts_act[1] = stat_en_r[1][`ASCM_S_CH1_FLOW_INPUT_SELECT] && pins_sy.rx_pin;
  assign rx_hold = pins_sy.carrier_n || hold_r;

  always_comb
  begin
    gated[0] = raw_flags_ch0;
    gated[1] = raw_flags_ch1;
    // only the flag is masked, the shifter keeps its tick stream
    gated[0].tx_holding_empty_flag =
      raw_flags_ch0.tx_holding_empty_flag && !cts_act[0];
    gated[1].tx_holding_empty_flag =
      raw_flags_ch1.tx_holding_empty_flag && !cts_act[1];
    if (rx_hold)
    begin
      gated[0].rx_holding_full_flag = 1'b0;
      gated[0].parity_error_flag = 1'b0;
      gated[0].framing_error_flag = 1'b0;
      gated[0].overrun_flag = 1'b0;
    end
  end

  // channel 0 flags double as dma request sources
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      flags_ch0 <= '0;
      flags_ch1 <= '0;
    end
    else
    begin
      flags_ch0 <= gated[0];
      flags_ch1 <= gated[1];
    end
  end

  // carrier bit and hold: a pin high in the read cycle wins over the clear
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      dcd_bit_r <= 1'b0;
      hold_r <= 1'b0;
    end
    else if (pins_sy.carrier_n)
    begin
      dcd_bit_r <= 1'b1;
      hold_r <= 1'b1;
    end
    else if (rd_channel0_status_reg)
    begin
      dcd_bit_r <= 1'b0;
      hold_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      async_clock_pin0_o <= 1'b0;
      async_clock_pin0_oe <= 1'b0;
      async_clock_pin1_o <= 1'b0;
      async_clock_pin1_oe <= 1'b0;
      dma_request_0_n <= 1'b1;
    end
    else
    begin
      async_clock_pin0_o <= data_clk[0];
      async_clock_pin0_oe <= !dma0_mem_io &&
        ctrl_b_r[0].speed_source != `ASCM_SS_EXTERNAL;
      async_clock_pin1_o <= clock_pin1_disable ? dma_transfer_end_0_n : data_clk[1];
      async_clock_pin1_oe <= clock_pin1_disable ||
        ctrl_b_r[1].speed_source != `ASCM_SS_EXTERNAL;
      dma_request_0_n <= dma0_mem_io ? pins_sy.clk_pin0 : 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      request_to_send0_n <= 1'b1;
    else
      request_to_send0_n <= ctrl_a_r[0][`ASCM_A_RTS];
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait, read data fetched in the address phase
  assign addr_ok = hsel && hready && htrans[1];
  assign rd_channel0_status_reg = addr_ok && !hwrite && haddr[7:0] == `ASCM_OFF_CHANNEL0_STATUS_REG;
  assign wr_byte = hwdata[7:0];

  always_comb
  begin
    rd_val = 8'h00;
    unique case (haddr[7:0])
      `ASCM_OFF_CTRL_A0: rd_val = ctrl_a_r[0];
      `ASCM_OFF_CTRL_A1: rd_val = ctrl_a_r[1];
      `ASCM_OFF_CTRL_B0:
      begin
        rd_val = ctrl_b_r[0];
        rd_val[`ASCM_B_PS] = pins_sy.clear_n;
      end
      `ASCM_OFF_CTRL_B1:
      begin
        rd_val = ctrl_b_r[1];
        rd_val[`ASCM_B_PS] = cts_act[1];
      end
      `ASCM_OFF_CHANNEL0_STATUS_REG:
      begin
        rd_val = stat_en_r[0];
        rd_val[`ASCM_S_RX_HOLDING_FULL_FLAG] = gated[0].rx_holding_full_flag;
        rd_val[`ASCM_S_OVERRUN_FLAG] = gated[0].overrun_flag;
        rd_val[`ASCM_S_PE] = gated[0].parity_error_flag;
        rd_val[`ASCM_S_FE] = gated[0].framing_error_flag;
        rd_val[`ASCM_S_DCD] = dcd_bit_r;
        rd_val[`ASCM_S_TX_HOLDING_EMPTY_FLAG] = gated[0].tx_holding_empty_flag;
      end
      `ASCM_OFF_CHANNEL1_STATUS_REG:
      begin
        rd_val = stat_en_r[1];
        rd_val[`ASCM_S_RX_HOLDING_FULL_FLAG] = gated[1].rx_holding_full_flag;
        rd_val[`ASCM_S_OVERRUN_FLAG] = gated[1].overrun_flag;
        rd_val[`ASCM_S_PE] = gated[1].parity_error_flag;
        rd_val[`ASCM_S_FE] = gated[1].framing_error_flag;
        rd_val[`ASCM_S_TX_HOLDING_EMPTY_FLAG] = gated[1].tx_holding_empty_flag;
      end
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr_r <= haddr[7:0];
      if (addr_ok && !hwrite)
        hrdata <= {24'h000000, rd_val};
    end
  end

  // control registers; data and shift state outside is untouched by reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctrl_a_r[0] <= `ASCM_RST_CTRL_A0;
      ctrl_a_r[1] <= `ASCM_RST_CTRL_A1;
    end
    else if (wr_pend_r && wr_addr_r == `ASCM_OFF_CTRL_A0)
      ctrl_a_r[0] <= wr_byte;
    else if (wr_pend_r && wr_addr_r == `ASCM_OFF_CTRL_A1)
      ctrl_a_r[1] <= wr_byte;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctrl_b_r[0] <= `ASCM_RST_CTRL_B;
      ctrl_b_r[1] <= `ASCM_RST_CTRL_B;
    end
    else if (wr_pend_r && wr_addr_r == `ASCM_OFF_CTRL_B0)
      ctrl_b_r[0] <= wr_byte;
    else if (wr_pend_r && wr_addr_r == `ASCM_OFF_CTRL_B1)
      ctrl_b_r[1] <= wr_byte;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      stat_en_r[0] <= `ASCM_RST_STAT;
      stat_en_r[1] <= `ASCM_RST_STAT;
    end
    else if (wr_pend_r && wr_addr_r == `ASCM_OFF_CHANNEL0_STATUS_REG)
      stat_en_r[0] <= wr_byte & `ASCM_WMASK_CHANNEL0_STATUS_REG;
    else if (wr_pend_r && wr_addr_r == `ASCM_OFF_CHANNEL1_STATUS_REG)
      stat_en_r[1] <= wr_byte & `ASCM_WMASK_CHANNEL1_STATUS_REG;
  end

endmodule

// file: verification/ascm_chk.sv
// assertion checker for the serial clocking block, bound to its top
`timescale 1ns/100ps
`include "ascm_defs.svh"
module ascm_chk
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic clear_to_send0_n,
  input wire logic carrier_detect0_n,
  input wire logic request_to_send0_n,
  input wire logic dma0_mem_io,
  input wire logic async_clock_pin0_oe,
  input ascm_pkg::ascm_flags_t raw_flags_ch0,
  input ascm_pkg::ascm_flags_t flags_ch0,
  input wire logic [1:0] sample_tick,
  input wire logic [1:0] bit_tick
);
  import ascm_pkg::*;
  logic take_c;
  logic rd_st0;
  logic wr_a0;
  assign take_c = hsel && hready && htrans[1];
  assign rd_st0 = take_c && !hwrite && haddr[7:0] == `ASCM_OFF_CHANNEL0_STATUS_REG;
  assign wr_a0 = take_c && hwrite && haddr[7:0] == `ASCM_OFF_CTRL_A0;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // pin windows of 8 cycles cover the three-stage synchroniser and flag reg
  sequence s_dcd_fall;
    carrier_detect0_n [*8] ##1 !carrier_detect0_n;
  endsequence
  sequence s_no_read;
    !rd_st0 [*8];
  endsequence
  a_cts_hold: assert property (
    clear_to_send0_n [*8] |-> !flags_ch0.tx_holding_empty_flag)
    else $error("tx empty flag not held low");
  a_cts_follow: assert property (
    (!clear_to_send0_n && raw_flags_ch0.tx_holding_empty_flag) [*8]
    |-> flags_ch0.tx_holding_empty_flag)
    else $error("tx empty flag not following holding state");
  a_dcd_hold: assert property (
    carrier_detect0_n [*8] |-> flags_ch0[3:0] == 4'h0)
    else $error("rx flags not held while carrier high");
  a_dcd_sticky: assert property (
    s_dcd_fall ##1 s_no_read |-> flags_ch0[3:0] == 4'h0)
    else $error("rx flags released without status read");
  a_read_frees: assert property (
    (!carrier_detect0_n) [*8] ##0 rd_st0 ##1
    (!carrier_detect0_n && raw_flags_ch0[3:0] == 4'hF) [*3]
    |-> flags_ch0[3:0] == 4'hF)
    else $error("rx flags still held after status read");
  // address edge, register edge, pin edge: the pin is seen one edge later
  a_rts_plain: assert property (
    $changed(request_to_send0_n) |-> $past(wr_a0, 3))
    else $error("request-to-send moved without a write");
  a_dma_pin0: assert property (
    dma0_mem_io [*2] |-> !async_clock_pin0_oe)
    else $error("clock pin 0 driven in dma mode");
  a_sample_gap: assert property (
    sample_tick[0] |=> !sample_tick[0] [*8])
    else $error("sample ticks too close");
  a_bit_gap: assert property (
    bit_tick[0] |=> !bit_tick[0] [*8])
    else $error("bit ticks too close");
endmodule

bind ascm_top ascm_chk u_ascm_chk
(
  .ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hready,
  .clear_to_send0_n, .carrier_detect0_n, .request_to_send0_n, .dma0_mem_io,
  .async_clock_pin0_oe, .raw_flags_ch0, .flags_ch0, .sample_tick, .bit_tick
);

// file: verification/ascm_modem.sv
// remote modem model: flow-control answer and external data clock
`timescale 1ns/100ps
module ascm_modem
#(
  parameter int CTS_DELAY = 20,
  parameter int EXT_HALF_NS = 200
)
(
  input wire logic ref_clk,
  input wire logic request_to_send0_n,
  input wire logic hold_off,
  input wire logic carrier_off,
  input wire logic ext_run,
  output logic clear_to_send0_n,
  output logic carrier_detect0_n,
  output logic ext_clk
);
  int wait_cnt = 0;
  // clock stands low between runs; 3 ns offset keeps edges off ref_clk
  initial
  begin
    ext_clk = 1'h0;
    #3;
    forever #(EXT_HALF_NS) ext_clk = ext_run & ~ext_clk;
  end
  // slow answer: clear only after CTS_DELAY cycles of request
  always @(posedge ref_clk)
  begin
    if (request_to_send0_n)
      wait_cnt <= 0;
    else if (wait_cnt < CTS_DELAY)
      wait_cnt <= wait_cnt + 1;
  end
  assign clear_to_send0_n = hold_off || request_to_send0_n ||
    wait_cnt < CTS_DELAY;
  assign carrier_detect0_n = carrier_off;
endmodule

// file: verification/tb.sv
// self-checking bench: ahb-lite register access and pin scenarios
`timescale 1ns/100ps
`include "ascm_defs.svh"
module tb;
  import ascm_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, request_to_send0_n, clear_to_send0_n;
  logic carrier_detect0_n, ext_clk, dma_request_0_n;
  logic async_clock_pin0_o, async_clock_pin0_oe;
  logic async_clock_pin1_o, async_clock_pin1_oe;
  logic sync_serial_rx_pin = 1'h0;
  logic dma0_mem_io = 1'h0;
  logic dma_transfer_end_0_n = 1'h1;
  logic hold_off = 1'h0;
  logic carrier_off = 1'h0;
  logic ext_run = 1'h0;
  ascm_flags_t raw_flags_ch0 = 5'h0;
  ascm_flags_t raw_flags_ch1 = 5'h0;
  ascm_flags_t flags_ch0, flags_ch1;
  logic [1:0] sample_tick, bit_tick, parity_odd, parity_enable;
  logic [7:0] bv [6] = '{8'h00, 8'h09, 8'h20, 8'h28, 8'h07, 8'h0F};
  int be [6] = '{160, 1280, 480, 1920, 320, 1280};
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // shared pins: the block wins while it drives, else the modem clock
  wire logic async_clock_pin0_i = async_clock_pin0_oe ?
    async_clock_pin0_o : ext_clk;
  wire logic async_clock_pin1_i = async_clock_pin1_oe ?
    async_clock_pin1_o : ext_clk;
  ascm_top u_ascm_top
  (
    .ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .async_clock_pin0_i,
    .async_clock_pin0_o, .async_clock_pin0_oe, .async_clock_pin1_i,
    .async_clock_pin1_o, .async_clock_pin1_oe, .clear_to_send0_n,
    .carrier_detect0_n, .request_to_send0_n, .sync_serial_rx_pin,
    .dma0_mem_io, .dma_transfer_end_0_n, .dma_request_0_n, .raw_flags_ch0,
    .raw_flags_ch1, .flags_ch0, .flags_ch1, .sample_tick, .bit_tick,
    .parity_odd, .parity_enable
  );
  ascm_modem u_ascm_modem
  (
    .ref_clk, .request_to_send0_n, .hold_off, .carrier_off, .ext_run,
    .clear_to_send0_n, .carrier_detect0_n, .ext_clk
  );
  always #10 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one idle cycle before each transfer avoids the write-then-read hazard
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= ASCM_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    htrans <= ASCM_HTRANS_IDLE;
    hsel <= 1'h0;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    bus(1'h0, a, 8'h00);
    chk(nm, {24'h0, e}, q);
  endtask
  // third gap is steady; the first two may straddle a rate change
  // s: 0 bit tick 0, 1 sample tick 0, 2 sample tick 1, 3 rise of pin 0
  task automatic gap(input int s, input int e, input string nm);
    int n;
    logic p;
    logic hit;
    p = 1'h1;
    repeat (3)
    begin
      n = 0;
      do
      begin
        @(negedge ref_clk);
        n++;
        hit = s == 0 ? bit_tick[0] : s == 1 ? sample_tick[0] :
          s == 2 ? sample_tick[1] : async_clock_pin0_o && !p;
        p = async_clock_pin0_o;
      end
      while (hit !== 1'h1);
    end
    chk(nm, e, n);
  endtask
  task automatic reset_check;
    rd(`ASCM_OFF_CTRL_A0, 8'h10, "ctrl_a0");
    rd(`ASCM_OFF_CTRL_A1, 8'h00, "ctrl_a1");
    rd(`ASCM_OFF_CTRL_B0, {2'h0, clear_to_send0_n, 5'h07}, "ctrl_b0");
    rd(`ASCM_OFF_CHANNEL0_STATUS_REG, 8'h00, "channel0_status_reg");
    chk("oe_rts", 32'h1, {async_clock_pin0_oe, request_to_send0_n});
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'h1;
    reset_check();
    wr(8'h18, 8'hFF);
    rd(8'h18, 8'h00, "unmapped");
    for (int i = 0; i < 7; i++)
    begin
      wr(`ASCM_OFF_CTRL_B0, 8'(i));
      gap(1, 10 << i, "sample_gap");
    end
    chk("pin0_oe", 32'h1, async_clock_pin0_oe);
    gap(3, 640, "pin0_clk");
    for (int i = 0; i < 6; i++)
    begin
      wr(`ASCM_OFF_CTRL_B0, bv[i]);
      // modem clock restarts only after the switch, so no edge of the
      // new source lands inside the minimum sample spacing
      repeat (8) @(posedge ref_clk);
      ext_run <= bv[i][2:0] == `ASCM_SS_EXTERNAL;
      gap(0, be[i], "bit_gap");
    end
    chk("pin0_oe", 32'h0, async_clock_pin0_oe);
    wr(`ASCM_OFF_CTRL_B0, 8'h00);
    ext_run <= 1'h0;
    dma0_mem_io <= 1'h1;
    repeat (20) @(posedge ref_clk);
    chk("pin0_dma", 32'h0, {async_clock_pin0_oe, dma_request_0_n});
    dma0_mem_io <= 1'h0;
    repeat (8) @(posedge ref_clk);
    chk("pin0_dma", 32'h3, {async_clock_pin0_oe, dma_request_0_n});
    wr(`ASCM_OFF_CTRL_A1, 8'h10);
    dma_transfer_end_0_n <= 1'h0;
    repeat (4) @(posedge ref_clk);
    chk("pin1", 32'h2, {async_clock_pin1_oe, async_clock_pin1_o});
    dma_transfer_end_0_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
    chk("pin1", 32'h3, {async_clock_pin1_oe, async_clock_pin1_o});
    wr(`ASCM_OFF_CTRL_A1, 8'h00);
    repeat (4) @(posedge ref_clk);
    chk("pin1_oe", 32'h0, async_clock_pin1_oe);
    wr(`ASCM_OFF_CTRL_B0, 8'h10);
    repeat (4) @(posedge ref_clk);
    chk("parity", 32'h2, {parity_odd[0], parity_enable[0]});
    wr(`ASCM_OFF_CTRL_A0, 8'h12);
    repeat (4) @(posedge ref_clk);
    chk("parity", 32'h3, {parity_odd[0], parity_enable[0]});
    wr(`ASCM_OFF_CTRL_B0, 8'h00);
    raw_flags_ch0 <= 5'h10;
    repeat (10) @(posedge ref_clk);
    chk("parity", 32'h1, {parity_odd[0], parity_enable[0]});
    chk("flags0", 32'h0, flags_ch0);
    rd(`ASCM_OFF_CHANNEL0_STATUS_REG, 8'h00, "channel0_status_reg");
    wr(`ASCM_OFF_CTRL_A0, 8'h02);
    repeat (4) @(posedge ref_clk);
    chk("rts_par", 32'h1, {request_to_send0_n, parity_enable[0]});
    repeat (30) @(posedge ref_clk);
    chk("flags0", 32'h10, flags_ch0);
    rd(`ASCM_OFF_CHANNEL0_STATUS_REG, 8'h02, "channel0_status_reg");
    rd(`ASCM_OFF_CTRL_B0, 8'h00, "ctrl_b0");
    hold_off <= 1'h1;
    repeat (10) @(posedge ref_clk);
    chk("flags0", 32'h0, flags_ch0);
    hold_off <= 1'h0;
    raw_flags_ch0 <= 5'h0F;
    carrier_off <= 1'h1;
    repeat (10) @(posedge ref_clk);
    chk("flags0", 32'h0, flags_ch0);
    carrier_off <= 1'h0;
    repeat (12) @(posedge ref_clk);
    chk("flags0", 32'h0, flags_ch0);
    rd(`ASCM_OFF_CHANNEL0_STATUS_REG, 8'h04, "channel0_status_reg");
    repeat (4) @(posedge ref_clk);
    chk("flags0", 32'h0F, flags_ch0);
    rd(`ASCM_OFF_CHANNEL0_STATUS_REG, 8'hF0, "channel0_status_reg");
    raw_flags_ch1 <= 5'h10;
    sync_serial_rx_pin <= 1'h1;
    repeat (10) @(posedge ref_clk);
    chk("flags1", 32'h10, flags_ch1);
    wr(`ASCM_OFF_CHANNEL1_STATUS_REG, 8'h04);
    repeat (8) @(posedge ref_clk);
    chk("flags1", 32'h0, flags_ch1);
    rd(`ASCM_OFF_CTRL_B1, 8'h27, "ctrl_b1");
    sync_serial_rx_pin <= 1'h0;
    repeat (10) @(posedge ref_clk);
    chk("flags1", 32'h10, flags_ch1);
    wr(`ASCM_OFF_CTRL_B1, 8'h31);
    gap(2, 60, "sample_gap1");
    chk("parity1", 32'h2, {parity_odd[1], parity_enable[1]});
    raw_flags_ch0 <= 5'h0;
    raw_flags_ch1 <= 5'h0;
    rst_n <= 1'h0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'h1;
    reset_check();
    give_verdict();
  end
endmodule
